/* rtl/wkp_pkg.sv */
package wkp_pkg;
  // Register bus shape
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  // Register offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_FLAGS = 4'h1;
  localparam logic [3:0] REG_AL_SEC = 4'h2;
  localparam logic [3:0] REG_AL_MIN = 4'h3;
  localparam logic [3:0] REG_AL_HOUR = 4'h4;
  localparam logic [3:0] REG_AL_DAYDATE = 4'h5;
  localparam logic [3:0] REG_STATUS = 4'h6;
  // Control register fields
  localparam int CTRL_WAKE_EN = 0;
  localparam int CTRL_ALARM_IE = 1;
  localparam int CTRL_KICK_IE = 2;
  localparam int CTRL_PDOWN = 3;
  localparam int CTRL_RETAIN = 4;
  // Flag register fields
  localparam int FLG_ALARM = 0;
  localparam int FLG_KICK = 1;
  // Day/date alarm byte: day-of-week select and value width
  localparam int DD_SEL_BIT = 6;
  localparam int DD_VAL_W = 6;
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] ALARM_RST = 8'h00;
  // Timing
  localparam int CLK_NS = 100;
  localparam int KICK_MIN_NS = 2000;
  localparam int KICK_MIN_CYC = (KICK_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int POTO_S = 2;
  localparam int TICK_HZ = 1;
  // One extra tick covers the unknown phase of the first tick
  localparam int POTO_TICKS = POTO_S * TICK_HZ + 1;
  localparam int CNT_W = 4;

  // Current calendar time, BCD bytes
  typedef struct packed {
    logic [7:0] day;
    logic [7:0] date;
    logic [7:0] hour;
    logic [7:0] min;
    logic [7:0] sec;
  } wkp_time_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_RUN = 2'b10
  } wkp_state_e;
endpackage

/* rtl/wkp_kick_filter.sv */
`timescale 1ns/10ps
module wkp_kick_filter
  import wkp_pkg::*;
#(
  parameter int MIN_CYC = KICK_MIN_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Kick line and qualified event
  input wire logic kick_input_n_i,
  output logic kick_pulse_o
);
  typedef struct packed {
    logic [7:0] cnt;
    logic pulse;
  } wkp_kf_s;

  wkp_kf_s q, d;

  // Count low cycles; one pulse when the low time reaches the minimum
  always_comb begin
    d = q;
    d.pulse = 1'b0;
    if (kick_input_n_i) begin
      d.cnt = 8'h00;
    end else if (q.cnt != 8'(MIN_CYC)) begin
      d.cnt = q.cnt + 8'h01;
      d.pulse = (q.cnt == 8'(MIN_CYC - 1));
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign kick_pulse_o = q.pulse;
endmodule

/* rtl/wkp_power_ctrl.sv */
// How it works
// - Timed wake-up is armed only while wake_enable is one.
// - Kick detection needs no enable, only the auxiliary battery when unpowered.
// - Timed wake-up happens only while the oscillator runs.
// - Unpowered with wake enabled, day/date, hour, minute, second are compared.
// - The wake match ignores the alarm interrupt enable.
// - A wake match pulls the power request low and sets the alarm flag.
// - Unpowered on battery, a long enough kick pulse requests power, sets kick flag.
// - No main power before timeout: power request released unless retain select is one, interrupt left off.
// - The flag of a failed attempt stays set until software clears it.
// - Power in time: request held, interrupt driven, power-down bit cleared.
// - Powered, the power request stays on while the power-down bit is zero.
// - Software writes zeros to clear flags; interrupt drops unless others pend.
// - Powered: match sets alarm flag, kick sets kick flag, enabled ones interrupt.
// - Powered: enabled wake or kick events still assert the power request.
// - Power-down bit accepts one only with both flags already clear.
// - Power-down bit one releases the power request to high impedance.
// - Fully powered down, retain select one keeps the request, zero releases it.
// - A kick low pulse counts only if it lasts the minimum width.
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
module wkp_power_ctrl
  import wkp_pkg::*;
#(
  parameter int TIMEOUT_TICKS = POTO_TICKS,
  parameter int KICK_CYC = KICK_MIN_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  // Clock/calendar side
  input wire wkp_time_s time_i,
  input wire logic osc_tick_i,
  input wire logic osc_running_i,
  input wire logic other_irq_i,
  // Supplies
  input wire logic main_power_i,
  input wire logic aux_battery_supply_i,
  // Kick input
  input wire logic kick_input_n_i,
  // Open-drain outputs
  output logic power_request_n_o,
  output logic power_request_oe_n_o,
  output logic irq_n_o,
  output logic irq_oe_n_o
);
  typedef struct packed {
    wkp_state_e st;
    logic wake_enable;
    logic alarm_irq_enable;
    logic kick_irq_enable;
    logic power_down_ctrl;
    logic power_retain_select;
    logic alarm_flag;
    logic kick_flag;
    logic pon;
    logic match_prev;
    logic [7:0] al_sec;
    logic [7:0] al_min;
    logic [7:0] al_hour;
    logic [7:0] al_dd;
    logic [CNT_W-1:0] cnt;
    logic [DATA_W-1:0] rdata;
    logic req_oe_n;
    logic irq_oe_n;
    logic drv;
  } wkp_regs_s;

  wkp_regs_s q, d;
  logic kick_pulse;
  logic kick_ev;
  logic match_now;
  logic match_ev;
  logic wake_ev;
  logic req_on;
  logic irq_on;

  // Full day-or-date, hour, minute, second compare
  function automatic logic time_match(input wkp_time_s t, input logic [7:0] s, input logic [7:0] m,
                                      input logic [7:0] h, input logic [7:0] dd);
    logic [7:0] ref_dd;
    ref_dd = dd[DD_SEL_BIT] ? t.day : t.date;
    time_match = (t.sec == s) && (t.min == m) && (t.hour == h) &&
                 (ref_dd[DD_VAL_W-1:0] == dd[DD_VAL_W-1:0]);
  endfunction

  // Minimum-width kick qualifier
  wkp_kick_filter #(
    .MIN_CYC(KICK_CYC)
  ) u_kick (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .kick_input_n_i(kick_input_n_i),
    .kick_pulse_o(kick_pulse)
  );

  // Event qualification
  assign kick_ev = kick_pulse && (main_power_i || aux_battery_supply_i);
  assign match_now = osc_running_i && time_match(time_i, q.al_sec, q.al_min, q.al_hour, q.al_dd);
  assign match_ev = match_now && !q.match_prev;
  assign wake_ev = match_ev && q.wake_enable;

  // Next-state logic: bus, flags, sequencer, pins
  always_comb begin
    d = q;
    d.rdata = '0;
    d.match_prev = match_now;
    d.drv = 1'b0;
    // Register writes
    if (wr_i) begin
      unique case (addr_i)
        REG_CTRL: begin
          d.wake_enable = wdata_i[CTRL_WAKE_EN];
          d.alarm_irq_enable = wdata_i[CTRL_ALARM_IE];
          d.kick_irq_enable = wdata_i[CTRL_KICK_IE];
          d.power_retain_select = wdata_i[CTRL_RETAIN];
          if (!wdata_i[CTRL_PDOWN]) begin
            d.power_down_ctrl = 1'b0;
          end else if (!q.alarm_flag && !q.kick_flag) begin
            d.power_down_ctrl = 1'b1;
          end
        end
        REG_FLAGS: begin
          if (!wdata_i[FLG_ALARM]) begin
            d.alarm_flag = 1'b0;
          end
          if (!wdata_i[FLG_KICK]) begin
            d.kick_flag = 1'b0;
          end
        end
        REG_AL_SEC: d.al_sec = wdata_i;
        REG_AL_MIN: d.al_min = wdata_i;
        REG_AL_HOUR: d.al_hour = wdata_i;
        REG_AL_DAYDATE: d.al_dd = wdata_i;
        default: ;
      endcase
    end
    // Event flags, set beats a software clear
    if (match_ev && (main_power_i || q.wake_enable)) begin
      d.alarm_flag = 1'b1;
    end
    if (kick_ev) begin
      d.kick_flag = 1'b1;
    end
    // Power sequencer
    unique case (q.st)
      ST_IDLE: begin
        if (main_power_i) begin
          d.st = ST_RUN;
        end else if (wake_ev || kick_ev) begin
          d.st = ST_WAIT;
          d.cnt = '0;
        end
      end
      ST_WAIT: begin
        if (main_power_i) begin
          d.st = ST_RUN;
          d.power_down_ctrl = 1'b0;
          d.pon = 1'b1;
        end else if (osc_tick_i) begin
          d.cnt = q.cnt + CNT_W'(1);
          if (q.cnt == CNT_W'(TIMEOUT_TICKS - 1)) begin
            d.st = ST_IDLE;
          end
        end
      end
      ST_RUN: begin
        if (!main_power_i) begin
          d.st = ST_IDLE;
        end else if (wake_ev || (kick_ev && q.kick_irq_enable)) begin
          d.power_down_ctrl = 1'b0;
        end
      end
      default: d.st = ST_IDLE;
    endcase
    // Power-on interrupt holds until both flags are cleared
    if (!d.alarm_flag && !d.kick_flag) begin
      d.pon = 1'b0;
    end
    // Pin drive
    req_on = (d.st == ST_WAIT) ||
             ((d.st == ST_RUN) && !d.power_down_ctrl) ||
             ((d.st == ST_IDLE) && d.power_retain_select);
    irq_on = (d.st == ST_RUN) && main_power_i &&
             ((d.pon && (d.alarm_flag || d.kick_flag)) ||
              (d.alarm_flag && d.alarm_irq_enable) || (d.kick_flag && d.kick_irq_enable) ||
              other_irq_i);
    d.req_oe_n = !req_on;
    d.irq_oe_n = !irq_on;
    // Register reads
    if (rd_i) begin
      unique case (addr_i)
        REG_CTRL: begin
          d.rdata[CTRL_WAKE_EN] = q.wake_enable;
          d.rdata[CTRL_ALARM_IE] = q.alarm_irq_enable;
          d.rdata[CTRL_KICK_IE] = q.kick_irq_enable;
          d.rdata[CTRL_PDOWN] = q.power_down_ctrl;
          d.rdata[CTRL_RETAIN] = q.power_retain_select;
        end
        REG_FLAGS: begin
          d.rdata[FLG_ALARM] = q.alarm_flag;
          d.rdata[FLG_KICK] = q.kick_flag;
        end
        REG_AL_SEC: d.rdata = q.al_sec;
        REG_AL_MIN: d.rdata = q.al_min;
        REG_AL_HOUR: d.rdata = q.al_hour;
        REG_AL_DAYDATE: d.rdata = q.al_dd;
        REG_STATUS: d.rdata = {2'b00, q.req_oe_n, q.irq_oe_n, q.cnt[1:0], q.st};
        default: ;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.al_sec <= ALARM_RST;
      q.al_min <= ALARM_RST;
      q.al_hour <= ALARM_RST;
      q.al_dd <= ALARM_RST;
      q.req_oe_n <= 1'b1;
      q.irq_oe_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Outputs
  assign rdata_o = q.rdata;
  assign power_request_n_o = q.drv;
  assign power_request_oe_n_o = q.req_oe_n;
  assign irq_n_o = q.drv;
  assign irq_oe_n_o = q.irq_oe_n;

  // Checks
  sequence s_waiting_last_tick;
    q.st == ST_WAIT && !main_power_i && osc_tick_i && q.cnt == CNT_W'(TIMEOUT_TICKS - 1);
  endsequence

  sequence s_power_arrives;
    q.st == ST_WAIT && main_power_i;
  endsequence

  AST_WAKE_ARM: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (q.st == ST_IDLE && !main_power_i && !q.wake_enable && !kick_ev) |=> q.st != ST_WAIT)
    else $error("wake-up started while disarmed");
  AST_OSC_GATE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !osc_running_i |-> !match_now)
    else $error("match seen with oscillator stopped");
  AST_WAKE_REQ: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (q.st == ST_IDLE && !main_power_i && wake_ev) |=> (!power_request_oe_n_o && q.alarm_flag) ##1 q.alarm_flag)
    else $error("wake match did not request power");
  AST_KICK_REQ: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (q.st == ST_IDLE && !main_power_i && kick_ev) |=> (!power_request_oe_n_o && q.kick_flag && q.st == ST_WAIT))
    else $error("kick did not request power");
  AST_TIMEOUT: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    s_waiting_last_tick |=> (q.st == ST_IDLE && irq_oe_n_o && power_request_oe_n_o == !q.power_retain_select))
    else $error("timeout did not release the request");
  AST_POWER_ON: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    s_power_arrives ##1 main_power_i |-> (!power_request_oe_n_o && !irq_oe_n_o && !q.power_down_ctrl))
    else $error("power-on did not hold request and raise interrupt");
  AST_PDOWN_GUARD: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (wr_i && addr_i == REG_CTRL && !q.power_down_ctrl && (q.alarm_flag || q.kick_flag)) |=> !q.power_down_ctrl)
    else $error("power-down accepted with a flag set");
  AST_PDOWN_REL: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (q.st == ST_RUN && q.power_down_ctrl && main_power_i && !wr_i && !wake_ev && !kick_ev) |=> power_request_oe_n_o)
    else $error("power-down did not release the request");
  AST_KICK_WIDTH: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    $rose(kick_pulse) |-> !$past(kick_input_n_i, KICK_CYC))
    else $error("kick accepted below minimum width");
  AST_KICK_ONE_SHOT: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    kick_pulse |=> !kick_pulse)
    else $error("kick filter gave two pulses in a row");

  // Unpowered gating of the two wake sources
  sequence s_idle_no_kick_osc_off;
    q.st == ST_IDLE && !main_power_i && !osc_running_i && !kick_ev;
  endsequence

  sequence s_idle_no_aux;
    q.st == ST_IDLE && !main_power_i && !aux_battery_supply_i && !wake_ev;
  endsequence

  AST_KICK_NO_AUX: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    s_idle_no_aux |=> q.st != ST_WAIT)
    else $error("kick started a power-on without the auxiliary battery");
  AST_OSC_NO_WAKE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    s_idle_no_kick_osc_off |=> q.st == ST_IDLE)
    else $error("power-on started with the oscillator stopped");
  AST_WAKE_IGNORES_IE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (q.st == ST_IDLE && !main_power_i && wake_ev && !q.alarm_irq_enable) |=> q.st == ST_WAIT)
    else $error("wake match gated by the alarm interrupt enable");
  AST_WAKE_FLAG: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (!main_power_i && wake_ev) |=> q.alarm_flag)
    else $error("wake match did not set the alarm flag");
  AST_REQ_WAIT: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    q.st == ST_WAIT |-> !power_request_oe_n_o)
    else $error("power request not driven while waiting for supply");
  AST_IRQ_UNPOWERED: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !main_power_i |=> irq_oe_n_o)
    else $error("interrupt driven without main power");

  // Flags only fall on a software write
  AST_ALARM_HOLD: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (q.alarm_flag && !(wr_i && addr_i == REG_FLAGS)) |=> q.alarm_flag)
    else $error("alarm flag dropped without a flag write");
  AST_KICK_HOLD: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (q.kick_flag && !(wr_i && addr_i == REG_FLAGS)) |=> q.kick_flag)
    else $error("kick flag dropped without a flag write");
  AST_PDOWN_HOLD: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (q.st == ST_RUN && main_power_i && !q.power_down_ctrl && !(wr_i && addr_i == REG_CTRL)) |=>
      !power_request_oe_n_o)
    else $error("power request dropped with power-down bit clear");
  AST_IRQ_CLEAR: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (!q.alarm_flag && !q.kick_flag && !other_irq_i && !match_ev && !kick_ev) |=> irq_oe_n_o)
    else $error("interrupt held with no source pending");
  AST_POWERED_ALARM: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (main_power_i && match_ev) |=> q.alarm_flag)
    else $error("powered match did not set the alarm flag");
  AST_POWERED_KICK: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    kick_ev |=> q.kick_flag)
    else $error("kick did not set the kick flag");

  // Powered events and full power-down
  sequence s_run_wake;
    q.st == ST_RUN && main_power_i && wake_ev;
  endsequence

  AST_RUN_EVENT: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    s_run_wake |=> (!q.power_down_ctrl && !power_request_oe_n_o))
    else $error("powered wake event did not assert the request");
  AST_RETAIN: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (q.st == ST_IDLE && !main_power_i && !wake_ev && !kick_ev && !(wr_i && addr_i == REG_CTRL)) |=>
      power_request_oe_n_o == !q.power_retain_select)
    else $error("powered-down request does not follow retain select");

  sequence s_wait_no_tick;
    q.st == ST_WAIT && !main_power_i && !osc_tick_i;
  endsequence

  AST_WAIT_NO_TICK: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    s_wait_no_tick |=> q.st == ST_WAIT)
    else $error("timeout advanced without an oscillator tick");
  AST_WAIT_BOUND: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    q.st == ST_WAIT |-> q.cnt < CNT_W'(TIMEOUT_TICKS))
    else $error("timeout counter ran past its limit");
endmodule

/* testbench/wkp_supply_model.sv */
`timescale 1ns/10ps
module wkp_supply_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Bench controls
  input wire logic enable_i,
  input wire logic [7:0] delay_i,
  // Power request pin enable from the block
  input wire logic power_request_oe_n_i,
  // Main supply status
  output logic main_power_o
);
  logic [7:0] cnt_q;

  // Supply ramps after a delay while requested, drops as soon as released
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q <= 8'h00;
      main_power_o <= 1'b0;
    end else if (power_request_oe_n_i || !enable_i) begin
      cnt_q <= 8'h00;
      main_power_o <= 1'b0;
    end else if (cnt_q == delay_i) begin
      main_power_o <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule

/* testbench/wakeup_kickstart_power_control_test.sv */
`timescale 1ns/10ps
module wakeup_kickstart_power_control_test import wkp_pkg::*; ;
  logic clk_i, arst_n_i, wr_i, rd_i, osc_tick_i, osc_running_i, other_irq_i, main_power_i;
  logic aux_battery_supply_i, kick_input_n_i, req_n, req_oe_n, irq_n, irq_oe_n, sup_en, rd_seen;
  logic [ADDR_W-1:0] addr_i;
  logic [DATA_W-1:0] wdata_i, rdata_o, asec;
  logic [7:0] sup_dly;
  logic [7:0] exp_q[$];
  wkp_time_s time_i;
  int mismatches, comparisons, seed, tick_cnt;

  wkp_power_ctrl #(.TIMEOUT_TICKS(2), .KICK_CYC(3)) u_dut (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .time_i(time_i), .osc_tick_i(osc_tick_i),
    .osc_running_i(osc_running_i), .other_irq_i(other_irq_i), .main_power_i(main_power_i),
    .aux_battery_supply_i(aux_battery_supply_i), .kick_input_n_i(kick_input_n_i),
    .power_request_n_o(req_n), .power_request_oe_n_o(req_oe_n), .irq_n_o(irq_n), .irq_oe_n_o(irq_oe_n));

  wkp_supply_model u_supply (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .enable_i(sup_en), .delay_i(sup_dly),
    .power_request_oe_n_i(req_oe_n), .main_power_o(main_power_i));

  // Clock, 100 ns period
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // Oscillator tick every 50 cycles
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tick_cnt <= 0;
      osc_tick_i <= 1'b0;
    end else begin
      tick_cnt <= (tick_cnt == 49) ? 0 : tick_cnt + 1;
      osc_tick_i <= (tick_cnt == 49);
    end
  end

  // Read data checked against the oldest note in the cycle after the strobe
  always @(posedge clk_i) rd_seen <= rd_i;
  always @(negedge clk_i) begin
    if (rd_seen === 1'b1) begin
      chk(rdata_o, exp_q.pop_front());
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic pin(input logic seen, input logic exp);
    chk({7'h00, seen}, {7'h00, exp});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_i);
    exp_q.push_back(e);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask

  // Calendar time with a chosen minute
  task automatic tm(input logic [7:0] m);
    @(posedge clk_i);
    time_i <= {8'h03, 8'h15, 8'h12, m, asec};
  endtask

  // Kick line held low for n cycles
  task automatic kick(input int n);
    @(posedge clk_i);
    kick_input_n_i <= 1'b0;
    repeat (n) @(posedge clk_i);
    kick_input_n_i <= 1'b1;
  endtask

  task automatic end_of_test();
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    #2000000;
    mismatches++;
    end_of_test();
  end

  initial begin
    seed = 32'he1c5a20a;
    arst_n_i = 1'b0;
    {wr_i, rd_i, other_irq_i, sup_en} = 4'h0;
    {osc_running_i, aux_battery_supply_i, kick_input_n_i} = 3'h7;
    addr_i = 4'h0;
    wdata_i = 8'h00;
    sup_dly = 8'h14;
    time_i = '0;
    asec = $random(seed);
    cyc(10);
    arst_n_i = 1'b1;
    // Reset state and unmapped read
    rd(REG_CTRL, CTRL_RST);
    rd(REG_FLAGS, 8'h00);
    rd(4'hF, 8'h00);
    cyc(1);
    pin(req_oe_n, 1'b1);
    pin(irq_oe_n, 1'b1);
    $display("test reset done");
    // Alarm set up, wake disabled and oscillator stopped
    wr(REG_AL_SEC, asec);
    wr(REG_AL_MIN, 8'h30);
    wr(REG_AL_HOUR, 8'h12);
    wr(REG_AL_DAYDATE, 8'h15);
    rd(REG_AL_MIN, 8'h30);
    tm(8'h30);
    cyc(3);
    pin(req_oe_n, 1'b1);
    tm(8'h31);
    wr(REG_CTRL, 8'h09);
    rd(REG_CTRL, 8'h09);
    @(posedge clk_i);
    osc_running_i <= 1'b0;
    tm(8'h30);
    cyc(3);
    pin(req_oe_n, 1'b1);
    tm(8'h31);
    @(posedge clk_i);
    osc_running_i <= 1'b1;
    $display("test wake gating done");
    // Wake match powers the system
    sup_en <= 1'b1;
    tm(8'h30);
    cyc(3);
    pin(req_oe_n, 1'b0);
    pin(req_n, 1'b0);
    rd(REG_FLAGS, 8'h01);
    cyc(30);
    pin(irq_oe_n, 1'b0);
    pin(irq_n, 1'b0);
    pin(req_oe_n, 1'b0);
    rd(REG_CTRL, 8'h01);
    tm(8'h31);
    wr(REG_CTRL, 8'h09);
    rd(REG_CTRL, 8'h01);
    cyc(1);
    pin(req_oe_n, 1'b0);
    wr(REG_FLAGS, 8'h00);
    cyc(2);
    pin(irq_oe_n, 1'b1);
    @(posedge clk_i);
    other_irq_i <= 1'b1;
    cyc(2);
    pin(irq_oe_n, 1'b0);
    @(posedge clk_i);
    other_irq_i <= 1'b0;
    $display("test wake power on done");
    // Powered kick, then software power down
    wr(REG_CTRL, 8'h05);
    kick(5);
    cyc(2);
    pin(irq_oe_n, 1'b0);
    pin(req_oe_n, 1'b0);
    rd(REG_FLAGS, 8'h02);
    // Day-of-week alarm while powered
    wr(REG_AL_DAYDATE, 8'h43);
    tm(8'h30);
    cyc(2);
    rd(REG_FLAGS, 8'h03);
    tm(8'h31);
    wr(REG_FLAGS, 8'h00);
    wr(REG_CTRL, 8'h0D);
    cyc(2);
    pin(req_oe_n, 1'b1);
    cyc(3);
    pin(irq_oe_n, 1'b1);
    $display("test power down done");
    // Kick attempts with no supply answering
    sup_en <= 1'b0;
    kick(2);
    cyc(3);
    pin(req_oe_n, 1'b1);
    aux_battery_supply_i <= 1'b0;
    kick(5);
    cyc(3);
    pin(req_oe_n, 1'b1);
    aux_battery_supply_i <= 1'b1;
    kick(5);
    cyc(2);
    pin(req_oe_n, 1'b0);
    cyc(40);
    pin(req_oe_n, 1'b0);
    cyc(120);
    pin(req_oe_n, 1'b1);
    pin(irq_oe_n, 1'b1);
    rd(REG_FLAGS, 8'h02);
    rd(REG_STATUS, 8'h38);
    $display("test failed power on done");
    // Retain select in full power down
    wr(REG_CTRL, 8'h10);
    cyc(2);
    pin(req_oe_n, 1'b0);
    wr(REG_CTRL, 8'h00);
    cyc(2);
    pin(req_oe_n, 1'b1);
    $display("test retain done");
    cyc(2);
    end_of_test();
  end
endmodule
